//--- rtl/ftd_cfg.svh
// Notes on behaviour
// (RQ1) Byte AND/OR/XOR with working; zero only
// (RQ2) Increment/decrement file, skip when zero
// (RQ3) Rotate file through carry; carry only
// (RQ4) Bit clear/set/test; index and address; no flags
// (RQ5) Add literal to working; C, DC, Z
// (RQ6) Literal minus working; C, DC, Z
// (RQ7) Literal OR/XOR/AND into working; zero only
// (RQ8) Literal load, optionally returning in two cycles
// (RQ9) Standby and watchdog clear update timeout/powerdown
// (RQ10) Port read-modify-write reads pin levels
// (RQ11) Timer count write clears assigned prescaler
// (RQ12) Branch or true skip: second cycle NO_OPERATION
// (RQ13) Instruction cycle is four oscillator periods
// (RQ14) Byte add/subtract working; C, DC, Z
// (RQ15) Call, jump and returns take two cycles
// (RQ16) Clear, store, NO_OPERATION, move, complement, swap
`ifndef FTD_CFG_SVH
`define FTD_CFG_SVH

// Oscillator periods per instruction cycle
`define FTD_OSC_PER_CYC 4

// Register port offsets and control bits
`define FTD_REG_CTRL   8'h00
`define FTD_REG_STAT   8'h04
`define FTD_CTRL_PRESC 0
`define FTD_CTRL_RUN   1
`define FTD_CTRL_RST   2'h2

// File addresses of special registers
`define FTD_TMR_ADDR   7'h01
`define FTD_PORTA_ADDR 7'h05
`define FTD_SECOND_IO_PORT_ADDR 7'h06

// Opcode groups in the top two bits
`define FTD_GRP_BYTE 2'h0
`define FTD_GRP_BIT  2'h1
`define FTD_GRP_JUMP 2'h2
`define FTD_GRP_LIT  2'h3

// Byte group sub-ops
`define FTD_B_MISC 4'h0
`define FTD_B_CLR  4'h1
`define FTD_B_SUB  4'h2
`define FTD_B_DEC  4'h3
`define FTD_B_OR   4'h4
`define FTD_B_AND  4'h5
`define FTD_B_XOR  4'h6
`define FTD_B_ADD  4'h7
`define FTD_B_MOV  4'h8
`define FTD_B_COM  4'h9
`define FTD_B_INC  4'ha
`define FTD_B_DECS 4'hb
`define FTD_B_RRC  4'hc
`define FTD_B_RLC  4'hd
`define FTD_B_SWAP 4'he
`define FTD_B_INCS 4'hf

// Bit group selectors
`define FTD_BT_CLR  2'h0
`define FTD_BT_SET  2'h1
`define FTD_BT_TSTC 2'h2
`define FTD_BT_TSTS 2'h3

// Literal group sub-ops, wildcard form
`define FTD_L_MOVK 4'b00??
`define FTD_L_RETK 4'b01??
`define FTD_L_OR   4'b1000
`define FTD_L_AND  4'b1001
`define FTD_L_XOR  4'b1010
`define FTD_L_SUBK 4'b110?
`define FTD_L_ADDK 4'b111?

// Exact control words
`define FTD_W_SLEEP  14'h0063
`define FTD_W_WDTCLR 14'h0064
`define FTD_W_RET    14'h0008
`define FTD_W_RETIE  14'h0009
`define FTD_W_CLEAR_WORKING_OP   14'h0103
`define FTD_NOP_MASK 14'h009f

// Flag update sets {c, dc, z}
`define FTD_FL_CDCZ 3'h7
`define FTD_FL_Z    3'h1
`define FTD_FL_C    3'h4

`endif

//--- rtl/ftd_pkg.sv
package ftd_pkg;

	// Datapath operation select
	typedef enum logic [4:0] {
		op_nop, op_add, op_sub, op_and, op_or, op_xor, op_inc, op_dec,
		op_rlc, op_rrc, op_com, op_swap, op_move_file_op, op_movw, op_clr,
		op_bclr, op_bset, op_btc, op_bts, op_movk, op_slp, op_wdt
	} ftd_op_t;

	// Decoded controls toward the datapath
	typedef struct packed {
		ftd_op_t     op;        // Operation
		logic        dest_file; // Result written to file
		logic [6:0]  faddr;     // File address
		logic [2:0]  bit_idx;   // Bit index
		logic [10:0] lit;       // Literal or jump target
		logic        upd_c;     // Carry updated
		logic        upd_dc;    // Digit carry updated
		logic        upd_z;     // Zero updated
		logic        upd_to_pd; // Timeout and powerdown updated
		logic        skip_test; // Conditional skip instruction
		logic        branch;    // Program counter changes
		logic        push;      // Push return address
		logic        pop;       // Pop return address
		logic        gie_set;   // Re-enable interrupts
		logic        rd_pins;   // Read port from pins
		logic        clr_presc; // Clear timer prescaler
		logic        illegal;   // Reserved opcode
	} ftd_dec_t;

endpackage

//--- rtl/ftd_phase_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "ftd_cfg.svh"

module ftd_phase_div #(
	parameter int unsigned PERIODS = `FTD_OSC_PER_CYC
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_n_i,
	output logic [$clog2(PERIODS)-1:0]      phase_o,
	output logic                            cyc_en_o
);
	localparam int unsigned W = $clog2(PERIODS);
	localparam logic [W-1:0] LAST = W'(PERIODS - 1);

	logic [W-1:0] next_phase; // Next oscillator phase

	// (RQ13) four-phase cycle count
	always_comb begin
		next_phase = (phase_o == LAST) ? '0 : phase_o + 1'b1;
	end

	// Phase register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_o <= '0;
		end else begin
			phase_o <= next_phase;
		end
	end

	// End of instruction cycle pulse
	assign cyc_en_o = (phase_o == LAST);

endmodule
`default_nettype wire

//--- rtl/ftd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "ftd_cfg.svh"

module ftd_decoder
	import ftd_pkg::*;
#(
	parameter logic [6:0] TIMER_ADDR     = `FTD_TMR_ADDR,
	parameter logic [6:0] PORT_A_ADDR    = `FTD_PORTA_ADDR,
	parameter logic [6:0] SECOND_IO_PORT = `FTD_SECOND_IO_PORT_ADDR
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [13:0] instr_i,
	input  wire logic        test_true_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [7:0]       rdata_o,
	output ftd_dec_t         dec_o,
	output logic             dec_valid_o
);
	logic        rst_meta;    // Reset synchroniser stage one
	logic        rst_sync;    // Released reset copy
	logic        cyc_en;      // Last phase of instruction cycle
	logic        kill;        // Next cycle forced to NO_OPERATION
	logic [1:0]  ctrl;        // Control register
	logic [1:0]  next_ctrl;   // Next control value
	logic        second_cyc;  // Issued cycle is a forced NO_OPERATION
	logic        next_second; // Next forced NO_OPERATION flag
	ftd_dec_t    next_dec;    // Next decoded controls
	logic        next_valid;  // Next issue pulse
	logic [7:0]  next_rdata;  // Next read data

	// Reset release through two flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Instruction cycle enable
	ftd_phase_div #(
		.PERIODS (`FTD_OSC_PER_CYC)
	) u_div (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_sync),
		.phase_o   (),
		.cyc_en_o  (cyc_en)
	);

	// Split one word into datapath controls
	function automatic ftd_dec_t decode(input logic [13:0] w, input logic presc);
		ftd_dec_t r;
		r = '0;
		r.faddr = w[6:0];
		r.bit_idx = w[9:7];
		r.lit = w[10:0];
		r.dest_file = w[7];
		case (w[13:12])
			`FTD_GRP_BYTE: begin
				case (w[11:8])
					// (RQ16) store, NO_OPERATION and exact words
					`FTD_B_MISC: begin
						r.dest_file = 1'b0;
						if (w[7]) begin
							r.op = op_movw;
							r.dest_file = 1'b1;
						// (RQ9) standby with status update
						end else if (w == `FTD_W_SLEEP) begin
							r.op = op_slp;
							r.upd_to_pd = 1'b1;
						// (RQ9) watchdog clear with status update
						end else if (w == `FTD_W_WDTCLR) begin
							r.op = op_wdt;
							r.upd_to_pd = 1'b1;
						// (RQ15) returns pop the stack
						end else if (w == `FTD_W_RET || w == `FTD_W_RETIE) begin
							r.branch = 1'b1;
							r.pop = 1'b1;
							r.gie_set = w[0];
						end else if ((w & `FTD_NOP_MASK) != '0) begin
							r.illegal = 1'b1;
						end
					end
					// (RQ16) clear file or working
					`FTD_B_CLR: begin
						if (w[7] || w == `FTD_W_CLEAR_WORKING_OP) begin
							r.op = op_clr;
							r.upd_z = 1'b1;
						end else begin
							r.illegal = 1'b1;
						end
					end
					// (RQ14) add and subtract working; decrement and increment, zero only
					`FTD_B_SUB: begin
						r.op = op_sub;
						{r.upd_c, r.upd_dc, r.upd_z} = `FTD_FL_CDCZ;
					end
					`FTD_B_ADD: begin
						r.op = op_add;
						{r.upd_c, r.upd_dc, r.upd_z} = `FTD_FL_CDCZ;
					end
					`FTD_B_DEC: begin
						r.op = op_dec;
						r.upd_z = 1'b1;
					end
					`FTD_B_INC: begin
						r.op = op_inc;
						r.upd_z = 1'b1;
					end
					// (RQ1) logic with working, zero only
					`FTD_B_OR: begin
						r.op = op_or;
						r.upd_z = 1'b1;
					end
					`FTD_B_AND: begin
						r.op = op_and;
						r.upd_z = 1'b1;
					end
					`FTD_B_XOR: begin
						r.op = op_xor;
						r.upd_z = 1'b1;
					end
					// (RQ16) move, complement, swap
					`FTD_B_MOV: begin
						r.op = op_move_file_op;
						r.upd_z = 1'b1;
					end
					`FTD_B_COM: begin
						r.op = op_com;
						r.upd_z = 1'b1;
					end
					`FTD_B_SWAP: r.op = op_swap;
					// (RQ2) count and skip on zero
					`FTD_B_DECS: begin
						r.op = op_dec;
						r.skip_test = 1'b1;
					end
					`FTD_B_INCS: begin
						r.op = op_inc;
						r.skip_test = 1'b1;
					end
					// (RQ3) rotate through carry
					`FTD_B_RRC: begin
						r.op = op_rrc;
						r.upd_c = 1'b1;
					end
					`FTD_B_RLC: begin
						r.op = op_rlc;
						r.upd_c = 1'b1;
					end
					default: r.illegal = 1'b1;
				endcase
			end
			// (RQ4) bit operations leave flags alone
			`FTD_GRP_BIT: begin
				r.dest_file = (w[11:10] == `FTD_BT_CLR) || (w[11:10] == `FTD_BT_SET);
				r.skip_test = !r.dest_file;
				case (w[11:10])
					`FTD_BT_CLR:  r.op = op_bclr;
					`FTD_BT_SET:  r.op = op_bset;
					`FTD_BT_TSTC: r.op = op_btc;
					default:      r.op = op_bts;
				endcase
			end
			// (RQ15) call pushes, jump does not
			`FTD_GRP_JUMP: begin
				r.dest_file = 1'b0;
				r.branch = 1'b1;
				r.push = !w[11];
			end
			default: begin
				r.dest_file = 1'b0;
				casez (w[11:8])
					// (RQ8) literal load, optional return
					`FTD_L_MOVK: r.op = op_movk;
					`FTD_L_RETK: begin
						r.op = op_movk;
						r.branch = 1'b1;
						r.pop = 1'b1;
					end
					// (RQ7) literal logic, zero only
					`FTD_L_OR: begin
						r.op = op_or;
						r.upd_z = 1'b1;
					end
					`FTD_L_AND: begin
						r.op = op_and;
						r.upd_z = 1'b1;
					end
					`FTD_L_XOR: begin
						r.op = op_xor;
						r.upd_z = 1'b1;
					end
					// (RQ6) literal minus working
					`FTD_L_SUBK: begin
						r.op = op_sub;
						{r.upd_c, r.upd_dc, r.upd_z} = `FTD_FL_CDCZ;
					end
					// (RQ5) add literal to working
					`FTD_L_ADDK: begin
						r.op = op_add;
						{r.upd_c, r.upd_dc, r.upd_z} = `FTD_FL_CDCZ;
					end
					default: r.illegal = 1'b1;
				endcase
			end
		endcase
		// (RQ10) port rewrite reads pins
		r.rd_pins = r.dest_file && r.op != op_movw && r.op != op_clr &&
			(r.faddr == PORT_A_ADDR || r.faddr == SECOND_IO_PORT);
		// (RQ11) timer write clears prescaler
		r.clr_presc = r.dest_file && r.faddr == TIMER_ADDR && presc;
		return r;
	endfunction

	// (RQ12) branch or true skip kills the next cycle
	assign kill = dec_o.branch || (dec_o.skip_test && test_true_i);

	// Issue one decode per instruction cycle
	always_comb begin
		next_dec = dec_o;
		next_valid = 1'b0;
		next_second = second_cyc;
		if (cyc_en) begin
			next_valid = 1'b1;
			next_second = kill;
			if (kill || !ctrl[`FTD_CTRL_RUN]) begin
				next_dec = '0;
			end else begin
				next_dec = decode(instr_i, ctrl[`FTD_CTRL_PRESC]);
			end
		end
	end

	// Decode output registers
	always_ff @(posedge sys_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			dec_o <= '0;
			dec_valid_o <= 1'b0;
			second_cyc <= 1'b0;
		end else begin
			dec_o <= next_dec;
			dec_valid_o <= next_valid;
			second_cyc <= next_second;
		end
	end

	// Register port write and read
	always_comb begin
		next_ctrl = ctrl;
		next_rdata = 8'h00;
		if (wr_i && addr_i == `FTD_REG_CTRL) begin
			next_ctrl = wdata_i[1:0];
		end
		if (rd_i) begin
			case (addr_i)
				`FTD_REG_CTRL: next_rdata = {6'h00, ctrl};
				`FTD_REG_STAT: next_rdata = {1'b0, dec_o.op, dec_o.illegal, second_cyc};
				default:       next_rdata = 8'h00;
			endcase
		end
	end

	// Register port state
	always_ff @(posedge sys_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			ctrl <= `FTD_CTRL_RST;
			rdata_o <= 8'h00;
		end else begin
			ctrl <= next_ctrl;
			rdata_o <= next_rdata;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_sync);

	// A word is taken for decode
	sequence s_take;
		cyc_en && !kill && ctrl[`FTD_CTRL_RUN];
	endsequence

	// The datapath sees a killed cycle
	sequence s_killed;
		cyc_en && kill;
	endsequence

	a_cycle_four: assert property ( // (RQ13)
		dec_valid_o |=> !dec_valid_o [*3] ##1 dec_valid_o
	) else $error("issue spacing is not four clocks");

	a_kill_nop: assert property ( // (RQ12)
		s_killed |=> dec_o.op == op_nop && !dec_o.branch && second_cyc
	) else $error("second cycle not forced to NO_OPERATION");

	a_logic_file: assert property ( // (RQ1)
		s_take ##0 instr_i[13:8] == {`FTD_GRP_BYTE, `FTD_B_AND} |=>
		dec_o.op == op_and && dec_o.upd_z && !dec_o.upd_c &&
		dec_o.dest_file == $past(instr_i[7])
	) else $error("file AND decoded wrongly");

	a_skip_count: assert property ( // (RQ2)
		s_take ##0 instr_i[13:8] == {`FTD_GRP_BYTE, `FTD_B_INCS} |=>
		dec_o.op == op_inc && dec_o.skip_test && !dec_o.upd_z
	) else $error("increment skip decoded wrongly");

	a_rotate_c: assert property ( // (RQ3)
		dec_o.op inside {op_rlc, op_rrc} |-> dec_o.upd_c && !dec_o.upd_z && !dec_o.upd_dc
	) else $error("rotate flags wrong");

	a_bit_noflag: assert property ( // (RQ4)
		s_take ##0 instr_i[13:12] == `FTD_GRP_BIT |=>
		!dec_o.upd_c && !dec_o.upd_z && dec_o.bit_idx == $past(instr_i[9:7])
	) else $error("bit operation decoded wrongly");

	a_add_literal: assert property ( // (RQ5)
		s_take ##0 instr_i[13:9] == 5'h1f |=>
		dec_o.op == op_add && dec_o.upd_dc && !dec_o.dest_file && !dec_o.branch
	) else $error("literal add decoded wrongly");

	a_sub_literal: assert property ( // (RQ6)
		s_take ##0 instr_i[13:9] == 5'h1e |=>
		dec_o.op == op_sub && dec_o.upd_c && dec_o.lit[7:0] == $past(instr_i[7:0])
	) else $error("literal subtract decoded wrongly");

	a_ret_literal: assert property ( // (RQ8)
		s_take ##0 instr_i[13:10] == 4'hd |=>
		dec_o.op == op_movk && dec_o.pop ##4 dec_valid_o && dec_o.op == op_nop
	) else $error("literal return not two cycles");

	a_standby: assert property ( // (RQ9)
		s_take ##0 instr_i == `FTD_W_SLEEP |=> dec_o.op == op_slp && dec_o.upd_to_pd
	) else $error("standby word decoded wrongly");

	a_pin_read: assert property ( // (RQ10)
		dec_o.rd_pins |-> dec_o.dest_file &&
		(dec_o.faddr == PORT_A_ADDR || dec_o.faddr == SECOND_IO_PORT)
	) else $error("pin read on non-port write");

	a_prescaler: assert property ( // (RQ11)
		s_take ##0 instr_i[13:7] == {`FTD_GRP_BYTE, `FTD_B_MOV, 1'b1} &&
		instr_i[6:0] == TIMER_ADDR |=> dec_o.clr_presc == $past(ctrl[`FTD_CTRL_PRESC])
	) else $error("prescaler clear wrong");

endmodule
`default_nettype wire

//--- bench/ftd_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none

// Fetch unit and datapath stand-in
module ftd_fetch_model
	import ftd_pkg::*;
(
	input  wire ftd_dec_t    dec_i,       // Decode now executing
	input  wire logic [13:0] word_i,      // Next word from program memory
	input  wire logic        cond_i,      // Outcome of the executing test
	output logic [13:0]      instr_o,     // Word shown at the issue edge
	output logic             test_true_o  // Skip test result
);
	// Word held steady up to and past the issue edge
	assign instr_o = word_i;
	// Only a skip instruction can report a true test
	assign test_true_o = dec_i.skip_test & cond_i;
endmodule

`default_nettype wire

//--- bench/tb_fourteen_bit_instruction_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end

module tb_fourteen_bit_instruction_decoder
	import ftd_pkg::*;
;
	logic        sys_clk_i = 1'b0;  // Core clock
	logic        rst_n_i   = 1'b0;  // Reset, held at start
	logic [13:0] word      = 14'h0000; // Word for the fetch model
	logic        cond      = 1'b0;  // Test outcome for the datapath
	logic [13:0] instr_i;           // Word into the decoder
	logic        test_true_i;       // Test result into the decoder
	logic [7:0]  addr_i    = 8'h00; // Register address
	logic [7:0]  wdata_i   = 8'h00; // Register write data
	logic        wr_i      = 1'b0;  // Write strobe
	logic        rd_i      = 1'b0;  // Read strobe
	logic [7:0]  rdata_o;           // Read data
	ftd_dec_t    dec_o;             // Decode out
	logic        dec_valid_o;       // New decode pulse
	int          err_total   = 0;   // Mismatches
	int          check_count = 0;   // Comparisons

	// Device under test
	ftd_decoder dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
		.test_true_i(test_true_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .dec_o(dec_o), .dec_valid_o(dec_valid_o));

	// Far side model
	ftd_fetch_model fetch_u (.dec_i(dec_o), .word_i(word), .cond_i(cond),
		.instr_o(instr_i), .test_true_o(test_true_i));

	// 20 MHz clock
	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// Verdict and end of run
	task automatic wrap_up();
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Register write, one strobe cycle
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	// Register read, data checked in the following cycle only
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		`CHECK("rdata", e, rdata_o)
	endtask

	// Bounded wait for the next decode pulse
	task automatic sync(output int n);
		n = 0;
		do begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end while (dec_valid_o !== 1'b1 && n < 12);
		`CHECK("dec_valid", 1'b1, dec_valid_o)
	endtask

	// Present one word right after a pulse, then park a NO_OPERATION
	task automatic issue(input logic [13:0] w, input logic c);
		int n;
		sync(n);
		@(posedge sys_clk_i);
		word <= w;
		cond <= c;
		sync(n);
		`CHECK("cycle gap", 4, n + 1)
		@(posedge sys_clk_i);
		word <= 14'h0000;
		#1;
	endtask

	// Next decode is empty; status shows whether it was killed
	task automatic kill_chk(input logic e);
		int n;
		sync(n);
		`CHECK("killed dec", ftd_dec_t'(0), dec_o)
		reg_rd(8'h04, {7'h00, e});
	endtask

	// Decode one word and compare its controls
	task automatic chk(input logic [13:0] w, input ftd_op_t op, input logic d,
		input logic [2:0] f, input logic [5:0] k);
		issue(w, 1'b0);
		`CHECK("op", op, dec_o.op)
		`CHECK("dest", d, dec_o.dest_file)
		`CHECK("flags", f, {dec_o.upd_c, dec_o.upd_dc, dec_o.upd_z})
		`CHECK("ctl", k, {dec_o.upd_to_pd, dec_o.skip_test, dec_o.branch,
			dec_o.push, dec_o.pop, dec_o.gie_set})
		if (w[13]) `CHECK("lit", w[7:0], dec_o.lit[7:0])
		else `CHECK("faddr", w[6:0], dec_o.faddr)
		if (w[13:12] == 2'h2) `CHECK("target", w[10:0], dec_o.lit)
		if (w[13:12] == 2'h1) `CHECK("bit", w[9:7], dec_o.bit_idx)
		// Branches lose the following word
		if (k[3]) kill_chk(1'b1);
	endtask

	// Control register, unmapped place, status, reserved word, halt
	task automatic t_regs();
		reg_rd(8'h00, 8'h02);
		reg_rd(8'h10, 8'h00);
		reg_wr(8'h04, 8'hff);
		reg_rd(8'h00, 8'h02);
		issue(14'h0585, 1'b0);
		reg_rd(8'h04, 8'h0c);
		issue(14'h0001, 1'b0);
		reg_rd(8'h04, 8'h02);
		reg_wr(8'h00, 8'h00);
		issue(14'h3e12, 1'b0);
		`CHECK("halted", ftd_dec_t'(0), dec_o)
		reg_wr(8'h00, 8'h02);
	endtask

	// Every opcode form
	task automatic t_table();
		chk(14'h0585, op_and, 1'b1, 3'h1, 6'h00);
		chk(14'h0405, op_or, 1'b0, 3'h1, 6'h00);
		chk(14'h06a5, op_xor, 1'b1, 3'h1, 6'h00);
		chk(14'h0f85, op_inc, 1'b1, 3'h0, 6'h10);
		chk(14'h0b05, op_dec, 1'b0, 3'h0, 6'h10);
		chk(14'h0385, op_dec, 1'b1, 3'h1, 6'h00);
		chk(14'h0a05, op_inc, 1'b0, 3'h1, 6'h00);
		chk(14'h0d85, op_rlc, 1'b1, 3'h4, 6'h00);
		chk(14'h0c05, op_rrc, 1'b0, 3'h4, 6'h00);
		chk(14'h13a5, op_bclr, 1'b1, 3'h0, 6'h00);
		chk(14'h1605, op_bset, 1'b1, 3'h0, 6'h00);
		chk(14'h1a05, op_btc, 1'b0, 3'h0, 6'h10);
		chk(14'h1f85, op_bts, 1'b0, 3'h0, 6'h10);
		chk(14'h3e5a, op_add, 1'b0, 3'h7, 6'h00);
		chk(14'h3fa5, op_add, 1'b0, 3'h7, 6'h00);
		chk(14'h3c5a, op_sub, 1'b0, 3'h7, 6'h00);
		chk(14'h3d33, op_sub, 1'b0, 3'h7, 6'h00);
		chk(14'h3812, op_or, 1'b0, 3'h1, 6'h00);
		chk(14'h3a12, op_xor, 1'b0, 3'h1, 6'h00);
		chk(14'h3912, op_and, 1'b0, 3'h1, 6'h00);
		chk(14'h3712, op_movk, 1'b0, 3'h0, 6'h0a);
		chk(14'h3312, op_movk, 1'b0, 3'h0, 6'h00);
		chk(14'h0063, op_slp, 1'b0, 3'h0, 6'h20);
		chk(14'h0064, op_wdt, 1'b0, 3'h0, 6'h20);
		chk(14'h0785, op_add, 1'b1, 3'h7, 6'h00);
		chk(14'h0205, op_sub, 1'b0, 3'h7, 6'h00);
		chk(14'h2123, op_nop, 1'b0, 3'h0, 6'h0c);
		chk(14'h2923, op_nop, 1'b0, 3'h0, 6'h08);
		chk(14'h0008, op_nop, 1'b0, 3'h0, 6'h0a);
		chk(14'h0009, op_nop, 1'b0, 3'h0, 6'h0b);
		chk(14'h0185, op_clr, 1'b1, 3'h1, 6'h00);
		chk(14'h0103, op_clr, 1'b0, 3'h1, 6'h00);
		chk(14'h0085, op_movw, 1'b1, 3'h0, 6'h00);
		chk(14'h0060, op_nop, 1'b0, 3'h0, 6'h00);
		chk(14'h0805, op_move_file_op, 1'b0, 3'h1, 6'h00);
		chk(14'h0985, op_com, 1'b1, 3'h1, 6'h00);
		chk(14'h0e05, op_swap, 1'b0, 3'h0, 6'h00);
	endtask

	// True and false skip tests
	task automatic t_skip();
		issue(14'h1a05, 1'b1);
		kill_chk(1'b1);
		issue(14'h0f85, 1'b1);
		kill_chk(1'b1);
		issue(14'h1f85, 1'b0);
		kill_chk(1'b0);
	endtask

	// Port reads from pins, timer writes clear the prescaler
	task automatic t_pt();
		issue(14'h0886, 1'b0);
		`CHECK("rd_pins", 1'b1, dec_o.rd_pins)
		issue(14'h0086, 1'b0);
		`CHECK("rd_pins", 1'b0, dec_o.rd_pins)
		reg_wr(8'h00, 8'h03);
		issue(14'h0181, 1'b0);
		`CHECK("clr_presc", 1'b1, dec_o.clr_presc)
		issue(14'h1481, 1'b0);
		`CHECK("clr_presc", 1'b1, dec_o.clr_presc)
		issue(14'h0801, 1'b0);
		`CHECK("clr_presc", 1'b0, dec_o.clr_presc)
		reg_wr(8'h00, 8'h02);
		issue(14'h0181, 1'b0);
		`CHECK("clr_presc", 1'b0, dec_o.clr_presc)
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		t_regs();
		t_table();
		t_skip();
		t_pt();
		wrap_up();
	end

	// Watchdog against a hang
	initial begin
		#400000;
		err_total++;
		wrap_up();
	end
endmodule

`default_nettype wire
